/* omq_pkg.sv */
// Package for the outbound message queue pointer bank: register map,
// field layout, reset values, bus and event carriers, and the state type.
// Assumes a 32-bit APB register bus and one 100 MHz clock.
package omq_pkg;

    // Bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFS_FREE_LOW = 12'h528;
    localparam logic [ADDR_W-1:0] OFS_FREE_LOW_STEP = 12'h52c;
    localparam logic [ADDR_W-1:0] OFS_FREE_UP = 12'h530;
    localparam logic [ADDR_W-1:0] OFS_POST_LOW = 12'h534;
    localparam logic [ADDR_W-1:0] OFS_POST_UP = 12'h538;
    localparam logic [ADDR_W-1:0] OFS_POST_UP_STEP = 12'h53c;
    localparam logic [ADDR_W-1:0] OFS_HOST_LOC = 12'h540;
    localparam logic [ADDR_W-1:0] OFS_HOST_MIRROR = 12'h544;
    localparam logic [ADDR_W-1:0] OFS_FRAME_POST = 12'h548;

    // Field layout
    localparam int PTR_W = 18;
    localparam int PTR_LSB = 2;
    localparam int BASE_W = 12;
    localparam int BASE_LSB = 20;
    localparam int IDX_W = 30;
    localparam int IDX_LSB = 2;
    localparam int LOC_W = 10;
    localparam int LOC_LSB = 2;
    localparam int SIZE_W = 2;
    localparam int STEP_BIT = 0;

    // Reset values and step size (one field unit is four bytes)
    localparam logic [PTR_W-1:0] PTR_RESET = 18'h0;
    localparam logic [PTR_W-1:0] PTR_STEP = 18'h1;
    localparam logic [BASE_W-1:0] BASE_RESET = 12'h0;
    localparam logic [LOC_W-1:0] LOC_RESET = 10'h0;
    localparam logic [IDX_W-1:0] IDX_RESET = 30'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0;

    // APB request as the master drives it
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } omq_apb_req_t;

    // APB answer
    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } omq_apb_rsp_t;

    // Events from the PCI target image, same clock, one-cycle pulses
    typedef struct packed {
        logic queueWrite;
        logic queueRead;
        logic hostIdxWrite;
        logic [IDX_W-1:0] hostIdxData;
    } omq_pci_evt_t;

    // Bus phase, Gray along idle -> answer -> idle
    typedef enum logic [0:0] {
        PH_IDLE = 1'b0,
        PH_ACK = 1'b1
    } omq_phase_t;

    // Whole state of the bank apart from the four list pointers
    typedef struct packed {
        omq_phase_t phase;
        omq_apb_rsp_t rsp;
        logic freeLowStep;
        logic postUpStep;
        logic [BASE_W-1:0] base;
        logic [LOC_W-1:0] hostLoc;
        logic [IDX_W-1:0] hostIdx;
        logic [IDX_W-1:0] postIdx;
        logic irqFlag;
    } omq_state_t;

endpackage

/* omq_list_ptr.sv */
// One word-aligned list pointer: software load and a one-word step.
// Assumes load and step come from logic on the same clock.
`timescale 1ns/100ps
module omq_list_ptr #(
    parameter int W = omq_pkg::PTR_W,
    parameter logic [W-1:0] RESET = omq_pkg::PTR_RESET,
    parameter logic [W-1:0] STEP = omq_pkg::PTR_STEP
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic [W-1:0] loadValue,
    input wire logic step,
    // Pointer field, counted in words
    output logic [W-1:0] ptr
);

    typedef struct packed {
        logic [W-1:0] ptr;
    } omq_ptr_state_t;

    omq_ptr_state_t st;
    omq_ptr_state_t next_st;

    // Load beats step so a software initialisation is never half undone
    always_comb begin
        next_st = st;
        if (load) begin
            next_st.ptr = loadValue;
        end else if (step) begin
            next_st.ptr = st.ptr + STEP;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st.ptr <= RESET;
        end else begin
            st <= next_st;
        end
    end

    assign ptr = st.ptr;

endmodule

/* omq_outbound_regs.sv */
// Outbound message queue pointer bank: list pointers, step strobes,
// host and processor outbound indices and the post list flag.
// Assumes an APB master on clk; PCI events and control bits arrive
// from logic on the same clock; rst is the primary reset.
`timescale 1ns/100ps
module omq_outbound_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire omq_pkg::omq_apb_req_t apbReq,
    output omq_pkg::omq_apb_rsp_t apbRsp,
    // PCI target image events
    input wire omq_pkg::omq_pci_evt_t pciEvt,
    // Control bits held in the I2O control and status register
    input wire logic outboundOptionEnable,
    input wire logic [omq_pkg::SIZE_W-1:0] hostListSizeSel,
    input wire logic [omq_pkg::BASE_W-1:0] localWindowBase,
    // To the queue and target image logic
    output logic [omq_pkg::PTR_W-1:0] freeLowPtr,
    output logic [omq_pkg::PTR_W-1:0] freeUpPtr,
    output logic [omq_pkg::PTR_W-1:0] postLowPtr,
    output logic [omq_pkg::PTR_W-1:0] postUpPtr,
    output logic [omq_pkg::LOC_W-1:0] hostIndexLocation,
    output logic [omq_pkg::IDX_W-1:0] hostIndexMirror,
    output logic postListIrqFlag
);

    omq_pkg::omq_state_t st;
    omq_pkg::omq_state_t next_st;

    logic commit;
    logic wrCommit;
    logic [omq_pkg::PTR_W-1:0] wrPtr;
    logic loadFreeLow;
    logic loadFreeUp;
    logic loadPostLow;
    logic loadPostUp;

    // Clear the index bits below the list size alignment
    function automatic logic [omq_pkg::IDX_W-1:0] alignIdx(
        input logic [omq_pkg::IDX_W-1:0] v,
        input logic [omq_pkg::SIZE_W-1:0] sel
    );
        logic [omq_pkg::IDX_W-1:0] r;
        r = v;
        for (int i = 0; i < omq_pkg::IDX_W; i++) begin
            if (i < int'(sel)) begin
                r[i] = 1'b0;
            end
        end
        return r;
    endfunction

    // Pointer register image: base on top, word offset, two zero bits
    function automatic logic [omq_pkg::DATA_W-1:0] ptrWord(
        input logic [omq_pkg::BASE_W-1:0] base,
        input logic [omq_pkg::PTR_W-1:0] p
    );
        logic [omq_pkg::DATA_W-1:0] w;
        w = omq_pkg::DATA_ZERO;
        w[omq_pkg::BASE_LSB +: omq_pkg::BASE_W] = base;
        w[omq_pkg::PTR_LSB +: omq_pkg::PTR_W] = p;
        return w;
    endfunction

    // A transfer completes at the edge where the access phase sees pready
    assign commit = (st.phase == omq_pkg::PH_ACK) && apbReq.psel
        && apbReq.penable;
    assign wrCommit = commit && apbReq.pwrite && !st.rsp.pslverr;
    assign wrPtr = apbReq.pwdata[omq_pkg::PTR_LSB +: omq_pkg::PTR_W];
    assign loadFreeLow = wrCommit && (apbReq.paddr == omq_pkg::OFS_FREE_LOW);
    assign loadFreeUp = wrCommit && (apbReq.paddr == omq_pkg::OFS_FREE_UP);
    assign loadPostLow = wrCommit && (apbReq.paddr == omq_pkg::OFS_POST_LOW);
    assign loadPostUp = wrCommit && (apbReq.paddr == omq_pkg::OFS_POST_UP);

    // Free list: processor steps the low end, PCI writes the upper end
    omq_list_ptr #(.W(omq_pkg::PTR_W)) freeLowInst (
        .clk(clk),
        .rst(rst),
        .load(loadFreeLow),
        .loadValue(wrPtr),
        .step(st.freeLowStep),
        .ptr(freeLowPtr)
    );

    omq_list_ptr #(.W(omq_pkg::PTR_W)) freeUpInst (
        .clk(clk),
        .rst(rst),
        .load(loadFreeUp),
        .loadValue(wrPtr),
        .step(pciEvt.queueWrite),
        .ptr(freeUpPtr)
    );

    // Post list: PCI reads step the low end, processor steps the upper end
    omq_list_ptr #(.W(omq_pkg::PTR_W)) postLowInst (
        .clk(clk),
        .rst(rst),
        .load(loadPostLow),
        .loadValue(wrPtr),
        .step(pciEvt.queueRead),
        .ptr(postLowPtr)
    );

    omq_list_ptr #(.W(omq_pkg::PTR_W)) postUpInst (
        .clk(clk),
        .rst(rst),
        .load(loadPostUp),
        .loadValue(wrPtr),
        .step(st.postUpStep),
        .ptr(postUpPtr)
    );

    // Bus phase, read data, strobes, indices and the flag
    always_comb begin
        next_st = st;
        next_st.base = localWindowBase;
        // A strobe lives one cycle; a new write 1 in that cycle wins
        next_st.freeLowStep = 1'b0;
        next_st.postUpStep = 1'b0;
        unique case (st.phase)
            omq_pkg::PH_IDLE: begin
                if (apbReq.psel && apbReq.penable) begin
                    next_st.phase = omq_pkg::PH_ACK;
                    next_st.rsp.pready = 1'b1;
                    next_st.rsp.pslverr = 1'b0;
                    next_st.rsp.prdata = omq_pkg::DATA_ZERO;
                    unique case (apbReq.paddr)
                        omq_pkg::OFS_FREE_LOW: begin
                            next_st.rsp.prdata = ptrWord(st.base, freeLowPtr);
                        end
                        omq_pkg::OFS_FREE_UP: begin
                            next_st.rsp.prdata = ptrWord(st.base, freeUpPtr);
                        end
                        omq_pkg::OFS_POST_LOW: begin
                            next_st.rsp.prdata = ptrWord(st.base, postLowPtr);
                        end
                        omq_pkg::OFS_POST_UP: begin
                            next_st.rsp.prdata = ptrWord(st.base, postUpPtr);
                        end
                        omq_pkg::OFS_FREE_LOW_STEP: begin
                            next_st.rsp.prdata[omq_pkg::STEP_BIT] =
                                st.freeLowStep;
                        end
                        omq_pkg::OFS_POST_UP_STEP: begin
                            next_st.rsp.prdata[omq_pkg::STEP_BIT] =
                                st.postUpStep;
                        end
                        omq_pkg::OFS_HOST_LOC: begin
                            next_st.rsp.prdata[omq_pkg::LOC_LSB +:
                                omq_pkg::LOC_W] = st.hostLoc;
                        end
                        omq_pkg::OFS_HOST_MIRROR: begin
                            next_st.rsp.prdata[omq_pkg::IDX_LSB +:
                                omq_pkg::IDX_W] = st.hostIdx;
                        end
                        omq_pkg::OFS_FRAME_POST: begin
                            next_st.rsp.prdata[omq_pkg::IDX_LSB +:
                                omq_pkg::IDX_W] = st.postIdx;
                        end
                        default: begin
                            // Unmapped: error answer, write dropped
                            next_st.rsp.pslverr = 1'b1;
                        end
                    endcase
                end
            end
            omq_pkg::PH_ACK: begin
                next_st.phase = omq_pkg::PH_IDLE;
                next_st.rsp.pready = 1'b0;
                next_st.rsp.pslverr = 1'b0;
            end
        endcase
        // Register writes take effect at the completing edge only
        if (wrCommit) begin
            unique case (apbReq.paddr)
                omq_pkg::OFS_FREE_LOW_STEP: begin
                    if (apbReq.pwdata[omq_pkg::STEP_BIT]) begin
                        next_st.freeLowStep = 1'b1;
                    end
                end
                omq_pkg::OFS_POST_UP_STEP: begin
                    if (apbReq.pwdata[omq_pkg::STEP_BIT]) begin
                        next_st.postUpStep = 1'b1;
                    end
                end
                omq_pkg::OFS_HOST_LOC: begin
                    next_st.hostLoc = apbReq.pwdata[omq_pkg::LOC_LSB +:
                        omq_pkg::LOC_W];
                end
                omq_pkg::OFS_HOST_MIRROR: begin
                    next_st.hostIdx = alignIdx(apbReq.pwdata[
                        omq_pkg::IDX_LSB +: omq_pkg::IDX_W],
                        hostListSizeSel);
                end
                omq_pkg::OFS_FRAME_POST: begin
                    next_st.postIdx = alignIdx(apbReq.pwdata[
                        omq_pkg::IDX_LSB +: omq_pkg::IDX_W],
                        hostListSizeSel);
                end
                default: begin
                end
            endcase
        end
        // The host's own update lands last, so it wins a same-cycle write
        if (pciEvt.hostIdxWrite) begin
            next_st.hostIdx = alignIdx(pciEvt.hostIdxData,
                hostListSizeSel);
        end
        // Level flag: follows the compare, forced low while disabled
        next_st.irqFlag = outboundOptionEnable
            && (st.hostIdx != st.postIdx);
    end

    // Every control bit has a defined value after the primary reset
    always_ff @(posedge clk) begin
        if (rst) begin
            st.phase <= omq_pkg::PH_IDLE;
            st.rsp.prdata <= omq_pkg::DATA_ZERO;
            st.rsp.pready <= 1'b0;
            st.rsp.pslverr <= 1'b0;
            st.freeLowStep <= 1'b0;
            st.postUpStep <= 1'b0;
            st.base <= omq_pkg::BASE_RESET;
            st.hostLoc <= omq_pkg::LOC_RESET;
            st.hostIdx <= omq_pkg::IDX_RESET;
            st.postIdx <= omq_pkg::IDX_RESET;
            st.irqFlag <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign apbRsp = st.rsp;
    assign hostIndexLocation = st.hostLoc;
    assign hostIndexMirror = st.hostIdx;
    assign postListIrqFlag = st.irqFlag;

    // Checks on the bank's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic idxDiff;
    assign idxDiff = outboundOptionEnable && (st.hostIdx != st.postIdx);

    free_low_step_a: assert property (
        st.freeLowStep && !loadFreeLow
        |=> freeLowPtr == $past(freeLowPtr) + omq_pkg::PTR_STEP)
        else $error("free low pointer missed its step");

    free_up_pci_a: assert property (
        pciEvt.queueWrite && !loadFreeUp
        |=> freeUpPtr == $past(freeUpPtr) + omq_pkg::PTR_STEP)
        else $error("free upper pointer missed a PCI write");

    post_low_pci_a: assert property (
        pciEvt.queueRead && !loadPostLow
        |=> postLowPtr == $past(postLowPtr) + omq_pkg::PTR_STEP)
        else $error("post low pointer missed a PCI read");

    post_up_step_a: assert property (
        wrCommit && apbReq.paddr == omq_pkg::OFS_POST_UP_STEP
        && apbReq.pwdata[omq_pkg::STEP_BIT] && !loadPostUp
        |=> ##1 postUpPtr == $past(postUpPtr, 2) + omq_pkg::PTR_STEP)
        else $error("post upper pointer not stepped by strobe");

    ptr_wrap_a: assert property (
        pciEvt.queueWrite && !loadFreeUp && (&freeUpPtr)
        |=> freeUpPtr == omq_pkg::PTR_RESET)
        else $error("free upper pointer did not wrap");

    step_zero_a: assert property (
        wrCommit && apbReq.paddr == omq_pkg::OFS_FREE_LOW_STEP
        && !apbReq.pwdata[omq_pkg::STEP_BIT]
        |=> !st.freeLowStep)
        else $error("writing zero fired the step strobe");

    base_read_a: assert property (
        commit && !apbReq.pwrite && apbReq.paddr == omq_pkg::OFS_FREE_UP
        |-> apbRsp.prdata[omq_pkg::BASE_LSB +: omq_pkg::BASE_W]
            == $past(st.base))
        else $error("window base missing from pointer read");

    loc_write_a: assert property (
        wrCommit && apbReq.paddr == omq_pkg::OFS_HOST_LOC
        |=> hostIndexLocation
            == $past(apbReq.pwdata[omq_pkg::LOC_LSB +: omq_pkg::LOC_W]))
        else $error("host index location not written");

    flag_set_a: assert property (
        idxDiff [*2] |-> postListIrqFlag)
        else $error("post list flag not set on index mismatch");

    flag_clear_a: assert property (
        (outboundOptionEnable && !idxDiff) [*2] |-> !postListIrqFlag)
        else $error("post list flag not cleared on equal indices");

    flag_disable_a: assert property (
        !outboundOptionEnable |=> !postListIrqFlag)
        else $error("post list flag raised while option disabled");

    apb_pulse_a: assert property (
        apbRsp.pready |=> !apbRsp.pready)
        else $error("pready held longer than one cycle");

    step_write_c: cover property (
        st.freeLowStep ##1 freeLowPtr != $past(freeLowPtr));
    pci_read_c: cover property (pciEvt.queueRead ##1 pciEvt.queueRead);
    flag_rise_c: cover property (!postListIrqFlag ##1 postListIrqFlag);
    bad_addr_c: cover property (apbRsp.pready && apbRsp.pslverr);

endmodule

/* omq_host_model.sv */
// Far-side model: PCI host and target image raising queue events.
// Assumes it shares clk with the register bank it drives.
`timescale 1ns/100ps
module omq_host_model (
    // Clock
    input wire logic clk,
    // Events toward the bank
    output omq_pkg::omq_pci_evt_t evt
);
    // Quiet from time zero
    initial begin
        evt = '0;
    end

    // Queue accesses; gap 0 gives one per cycle, larger gaps a slow host
    task automatic queue(input logic wr, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            evt.queueWrite <= wr;
            evt.queueRead <= !wr;
            if (gap > 0) begin
                @(posedge clk);
                evt.queueWrite <= 1'b0;
                evt.queueRead <= 1'b0;
                repeat (gap - 1) @(posedge clk);
            end
        end
        @(posedge clk);
        evt.queueWrite <= 1'b0;
        evt.queueRead <= 1'b0;
    endtask

    // Host advances its outbound index; stale data is not left behind
    task automatic host_index(input logic [omq_pkg::IDX_W-1:0] d);
        @(posedge clk);
        evt.hostIdxWrite <= 1'b1;
        evt.hostIdxData <= d;
        @(posedge clk);
        evt.hostIdxWrite <= 1'b0;
        evt.hostIdxData <= ~d;
    endtask
endmodule

/* test_omq_outbound_regs.sv */
// Self-checking bench for the outbound queue pointer bank.
// Assumes one APB wait state and the event model on the PCI side.
`timescale 1ns/100ps
module test_omq_outbound_regs;
    // Bank inputs and outputs
    logic clk;
    logic rst;
    omq_pkg::omq_apb_req_t apbReq;
    omq_pkg::omq_apb_rsp_t apbRsp;
    omq_pkg::omq_pci_evt_t pciEvt;
    logic outboundOptionEnable;
    logic [1:0] hostListSizeSel;
    logic [11:0] localWindowBase;
    logic [17:0] freeLowPtr, freeUpPtr, postLowPtr, postUpPtr;
    logic [9:0] hostIndexLocation;
    logic [29:0] hostIndexMirror;
    logic postListIrqFlag;
    int error_cnt;
    int checks;
    logic [31:0] rd;
    logic err;
    localparam logic [11:0] OFS [9] = '{12'h528, 12'h52c, 12'h530,
        12'h534, 12'h538, 12'h53c, 12'h540, 12'h544, 12'h548};

    omq_outbound_regs u_dut (.clk(clk), .rst(rst), .apbReq(apbReq),
        .apbRsp(apbRsp), .pciEvt(pciEvt),
        .outboundOptionEnable(outboundOptionEnable),
        .hostListSizeSel(hostListSizeSel),
        .localWindowBase(localWindowBase), .freeLowPtr(freeLowPtr),
        .freeUpPtr(freeUpPtr), .postLowPtr(postLowPtr),
        .postUpPtr(postUpPtr), .hostIndexLocation(hostIndexLocation),
        .hostIndexMirror(hostIndexMirror),
        .postListIrqFlag(postListIrqFlag));

    omq_host_model u_host (.clk(clk), .evt(pciEvt));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // All comparisons pass through here so the tally stays in one place
    task automatic cmp(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
            pwdata: d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        n = 0;
        // No local limit: only the watchdog ends a wait that never answers
        do begin
            @(posedge clk);
            n++;
        end while (apbRsp.pready !== 1'b1);
        // One wait state: pready is seen at the second edge of the access
        cmp("access edges", 32'h2, 32'(n));
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        cmp("pslverr", 32'h0, 32'(err));
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a,
        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(what, exp, rd);
    endtask

    // Primary reset, then every register, the four pointer ports and the flag back at zero
    task automatic s_reset();
        @(posedge clk);
        rst <= 1'b1;
        localWindowBase <= 12'h0;
        outboundOptionEnable <= 1'b0;
        hostListSizeSel <= 2'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        foreach (OFS[i]) rd_chk("reset reg", OFS[i], 32'h0);
        cmp("reset ptrs", 32'h0, 32'(freeLowPtr | freeUpPtr | postLowPtr
            | postUpPtr));
        cmp("reset flag", 32'h0, 32'(postListIrqFlag));
    endtask

    // Equal list pointers at start, window base read-only above them
    task automatic s_pointers();
        @(posedge clk);
        localWindowBase <= 12'ha5c;
        wr(12'h528, 32'h0000_1230);
        wr(12'h530, 32'h0000_1230);
        wr(12'h534, 32'hffff_fff0);
        wr(12'h538, 32'h000f_fff0);
        rd_chk("free low", 12'h528, 32'ha5c0_1230);
        rd_chk("post low", 12'h534, 32'ha5cf_fff0);
        rd_chk("free up", 12'h530, 32'ha5c0_1230);
        cmp("post up port", 32'h3fffc, 32'(postUpPtr));
    endtask

    // Step strobes, a write with the step bit clear, and a wrap at the field width
    task automatic s_steps();
        wr(12'h52c, 32'h1);
        rd_chk("free low step", 12'h528, 32'ha5c0_1234);
        wr(12'h52c, 32'hffff_fffe);
        rd_chk("free low hold", 12'h528, 32'ha5c0_1234);
        repeat (4) wr(12'h53c, 32'h1);
        rd_chk("post up wrap", 12'h538, 32'ha5c0_0000);
        rd_chk("strobe clear", 12'h53c, 32'h0);
        apb(1'b1, 12'h54c, 32'h1);
        cmp("unmapped err", 32'h1, 32'(err));
        rd_chk("free low kept", 12'h528, 32'ha5c0_1234);
    endtask

    // Back-to-back queue writes, slow queue reads
    task automatic s_events();
        u_host.queue(1'b1, 3, 0);
        u_host.queue(1'b0, 2, 2);
        @(negedge clk);
        cmp("free up port", 32'h48f, 32'(freeUpPtr));
        cmp("post low port", 32'h3fffe, 32'(postLowPtr));
        rd_chk("post low reg", 12'h534, 32'ha5cf_fff8);
        // Top of the field, then one PCI write must wrap to zero
        wr(12'h530, 32'h000f_fffc);
        u_host.queue(1'b1, 1, 0);
        @(negedge clk);
        cmp("free up wrap", 32'h0, 32'(freeUpPtr));
    endtask

    // Location field width, then a legal word-aligned place
    task automatic s_location();
        wr(12'h540, 32'hffff_ffff);
        rd_chk("location", 12'h540, 32'h0000_0ffc);
        wr(12'h540, 32'h0000_0100);
        @(negedge clk);
        cmp("location port", 32'h40, 32'(hostIndexLocation));
    endtask

    // Index compare gated by enable, cleared by host, alignment by size
    task automatic s_index();
        wr(12'h544, 32'h0000_1234);
        wr(12'h548, 32'h0000_1238);
        repeat (2) @(negedge clk);
        cmp("flag gated", 32'h0, 32'(postListIrqFlag));
        @(posedge clk);
        outboundOptionEnable <= 1'b1;
        repeat (2) @(negedge clk);
        cmp("flag set", 32'h1, 32'(postListIrqFlag));
        u_host.host_index(30'h48e);
        repeat (2) @(negedge clk);
        cmp("flag clear", 32'h0, 32'(postListIrqFlag));
        cmp("mirror port", 32'h48e, 32'(hostIndexMirror));
        rd_chk("mirror", 12'h544, 32'h0000_1238);
        rd_chk("frame post", 12'h548, 32'h0000_1238);
        @(posedge clk);
        hostListSizeSel <= 2'h2;
        wr(12'h544, 32'h0000_00fc);
        rd_chk("aligned", 12'h544, 32'h0000_00f0);
        wr(12'h548, 32'h0000_00fc);
        rd_chk("post aligned", 12'h548, 32'h0000_00f0);
    endtask

    // Verdict and end of run
    task automatic close_out();
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence; a mid-run reset closes it
    initial begin
        rst = 1'b1;
        apbReq = '0;
        outboundOptionEnable = 1'b0;
        hostListSizeSel = 2'h0;
        localWindowBase = 12'h0;
        error_cnt = 0;
        checks = 0;
        s_reset();
        s_pointers();
        s_steps();
        s_events();
        s_location();
        s_index();
        s_reset();
        close_out();
    end

    // Watchdog well beyond the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        close_out();
    end
endmodule
